// *** sar_conversion_control.sv ***
/*
 * Conversion control of a 16-bit successive-approximation converter:
 * start, acquisition, bit-by-bit approximation, coding, saturation, busy.
 * Assumes comparator and range flags come from front-end logic on clk;
 * every other control input is a pin and is synchronised here.
 */
`timescale 1ns/10ps
module sar_conversion_control
    import sar_conv_pkg::*;
#(
    parameter int GAP_LIMIT = GAP_CYCLES    // Shorten in simulation
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic conversion_start_n,
    input wire logic reset_input,
    input wire logic power_down_input,
    input wire logic high_rate_select,
    input wire logic rate_option,
    input wire logic output_coding_select,
    input wire logic comparator_high,
    input wire logic over_range,
    input wire logic under_range,
    output logic busy,
    output logic sample_hold,
    output logic [15:0] dac_trial,
    output sar_conv_pkg::result_t result,
    output sar_conv_pkg::rate_mode_t active_mode
);
    import sar_conv_pkg::*;

    localparam int GW = $clog2(GAP_LIMIT + 1);
    localparam int SW = $clog2(STEP_CYCLES + 1);
    localparam int AW = $clog2(ACQ_CYCLES + 1);
    localparam int BUSY_LEN = RES_BITS * STEP_CYCLES + 1;

    typedef enum logic [1:0] {ST_ACQ, ST_READY, ST_CONVERT, ST_FINISH} conv_state_t;

    // ==========================================================
    // Pin synchronisation
    // ==========================================================
    logic [5:0] pins_s;        // Synchronised pins
    logic start_n_s;           // Start, synchronised
    logic abort_s;             // Reset input, synchronised
    logic pd_s;                // Power-down, synchronised
    rate_mode_t straps_s;      // Rate straps, synchronised
    logic coding_s;            // Coding select, synchronised

    pin_sync #(.WIDTH(6)) u_pin_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .pins({conversion_start_n, reset_input, power_down_input,
               high_rate_select, rate_option, output_coding_select}),
        .synced(pins_s)
    );

    assign start_n_s = pins_s[5];
    assign abort_s = pins_s[4];
    assign pd_s = pins_s[3];
    assign straps_s = '{high_rate: pins_s[2], rate_option: pins_s[1]};
    assign coding_s = pins_s[0];

    // ==========================================================
    // State and datapath registers
    // ==========================================================
    conv_state_t state_ff;     // Conversion sequencer
    logic start_prev_ff;       // Last start level, for edge detect
    logic [AW-1:0] acq_cnt_ff; // Acquisition timer
    logic [SW-1:0] step_cnt_ff;// Conversion clock divider
    logic [3:0] bit_idx_ff;    // Bit under decision
    logic ovr_ff;              // Over range seen at hold
    logic und_ff;              // Under range seen at hold
    logic [GW-1:0] gap_cnt_ff; // Cycles since last launch
    logic first_ff;            // No launch since reset
    logic stale_pend_ff;       // Staleness of the running conversion
    logic start_fall;          // Falling edge of start
    logic start_ok;            // Accepted launch
    logic step_en;             // One approximation step
    logic fast_mode;           // Either fast mode strapped
    logic [15:0] nxt_code;     // Coded result being formed
    logic [15:0] bin_code;     // Saturated straight binary result

    assign start_fall = start_prev_ff && !start_n_s;
    // Acquisition must be complete and power-down low before launch
    assign start_ok = (state_ff == ST_READY) && start_fall && !pd_s && !abort_s;
    assign step_en = (state_ff == ST_CONVERT) && (step_cnt_ff == SW'(STEP_CYCLES - 1));
    // Both straps low is normal mode; high-rate high is a fast mode
    assign fast_mode = straps_s.high_rate;

    // Start edge history
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            start_prev_ff <= 1'b0;
        else
            start_prev_ff <= start_n_s;
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!reset_n || abort_s)
        begin
            state_ff <= ST_ACQ;
        end
        else
        begin
            unique case (state_ff)
                ST_ACQ:
                begin
                    // Tracking until the sample has settled
                    if (acq_cnt_ff == AW'(ACQ_CYCLES - 1))
                        state_ff <= ST_READY;
                end
                ST_READY:
                begin
                    if (start_ok)
                        state_ff <= ST_CONVERT;
                end
                ST_CONVERT:
                begin
                    if (step_en && bit_idx_ff == 4'h0)
                        state_ff <= ST_FINISH;
                end
                ST_FINISH:
                begin
                    // Power-down waits here for nothing; the next start is gated
                    state_ff <= ST_ACQ;
                end
            endcase
        end
    end

    // Acquisition timer
    always_ff @(posedge clk)
    begin
        if (!reset_n || abort_s || state_ff != ST_ACQ)
            acq_cnt_ff <= '0;
        else if (acq_cnt_ff != AW'(ACQ_CYCLES - 1))
            acq_cnt_ff <= acq_cnt_ff + AW'(1);
    end

    // Conversion clock: one step enable every STEP_CYCLES
    always_ff @(posedge clk)
    begin
        if (!reset_n || state_ff != ST_CONVERT || step_en)
            step_cnt_ff <= '0;
        else
            step_cnt_ff <= step_cnt_ff + SW'(1);
    end

    // ==========================================================
    // Successive approximation
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!reset_n || abort_s)
        begin
            dac_trial <= TRIAL_RST;
            bit_idx_ff <= BIT_IDX_RST;
        end
        else if (start_ok)
        begin
            // First trial is half scale: most significant bit first
            dac_trial <= MSB_TRIAL;
            bit_idx_ff <= 4'(MSB_POS);
        end
        else if (step_en)
        begin
            // Drop the trial bit if the sample lies below it
            if (!comparator_high)
                dac_trial[bit_idx_ff] <= 1'b0;
            if (bit_idx_ff != 4'h0)
            begin
                dac_trial[bit_idx_ff - 4'h1] <= 1'b1;
                bit_idx_ff <= bit_idx_ff - 4'h1;
            end
        end
    end

    // Range flags held with the sample
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            ovr_ff <= 1'b0;
            und_ff <= 1'b0;
        end
        else if (start_ok)
        begin
            ovr_ff <= over_range;
            und_ff <= under_range;
        end
    end

    // Sample-and-hold and busy follow the launch and the finish
    always_ff @(posedge clk)
    begin
        if (!reset_n || abort_s)
        begin
            busy <= 1'b0;
            sample_hold <= 1'b0;
        end
        else if (start_ok)
        begin
            busy <= 1'b1;
            sample_hold <= 1'b1;
        end
        else if (state_ff == ST_FINISH)
        begin
            busy <= 1'b0;
            sample_hold <= 1'b0;
        end
    end

    // ==========================================================
    // Output coding and saturation
    // ==========================================================
    always_comb
    begin
        // Out of range forces the end codes regardless of the search
        if (ovr_ff)
            bin_code = CODE_TOP;
        else if (und_ff)
            bin_code = CODE_BOTTOM;
        else
            bin_code = dac_trial;
        // Twos complement is binary with the sign bit inverted
        nxt_code = {bin_code[15] ^ !coding_s, bin_code[14:0]};
    end

    // Result is loaded as busy falls at the finish; an abort keeps the last result
    always_ff @(posedge clk)
    begin
        if (!reset_n)
            result <= RESULT_RST;
        else if (state_ff == ST_FINISH && !abort_s)
            result <= '{code: nxt_code, stale: stale_pend_ff};
    end

    // ==========================================================
    // Fast-mode gap tracking
    // ==========================================================
    // Flags, not blocks: the host decides to discard
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            gap_cnt_ff <= '0;
            first_ff <= 1'b1;
            stale_pend_ff <= 1'b0;
            active_mode <= MODE_RST;
        end
        else if (start_ok)
        begin
            gap_cnt_ff <= '0;
            first_ff <= 1'b0;
            // Normal mode has no gap limit
            stale_pend_ff <= fast_mode && (first_ff || gap_cnt_ff >= GW'(GAP_LIMIT));
            active_mode <= straps_s;
        end
        else if (gap_cnt_ff < GW'(GAP_LIMIT))
        begin
            gap_cnt_ff <= gap_cnt_ff + GW'(1);
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    logic [7:0] busy_len_ff;   // Busy length helper
    always_ff @(posedge clk)
    begin
        if (!reset_n || !busy)
            busy_len_ff <= '0;
        else
            busy_len_ff <= busy_len_ff + 8'h01;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    launch_busy_a: assert property (start_ok |=> busy && sample_hold)
        else $error("launch did not raise busy and hold");
    msb_first_a: assert property (start_ok |=> dac_trial == MSB_TRIAL ##STEP_CYCLES dac_trial[14])
        else $error("first trial not half scale");
    busy_len_a: assert property ($fell(busy) && !$past(abort_s) |-> busy_len_ff == 8'(BUSY_LEN))
        else $error("busy length wrong");
    finish_order_a: assert property ($fell(busy) && !$past(abort_s) |-> $past(state_ff) == ST_FINISH)
        else $error("busy fell outside finish");
    acq_refuse_a: assert property (state_ff == ST_ACQ && start_fall |=> !$rose(busy))
        else $error("launch during acquisition");
    abort_a: assert property (abort_s |=> !busy && state_ff == ST_ACQ)
        else $error("reset input did not abort");
    pd_refuse_a: assert property (pd_s && start_fall && !busy |=> !busy)
        else $error("launch during power-down");
    sat_top_a: assert property (state_ff == ST_FINISH && !abort_s && ovr_ff && coding_s
        |=> result.code == CODE_TOP)
        else $error("over range not saturated");
    twos_top_a: assert property (state_ff == ST_FINISH && !abort_s && ovr_ff && !coding_s
        |=> result.code == 16'h7FFF)
        else $error("twos complement top wrong");
    stale_a: assert property (start_ok && fast_mode && first_ff |=> stale_pend_ff)
        else $error("first fast result not flagged");

    conv_done_c: cover property (start_ok ##[1:40] $fell(busy));
    stale_c: cover property (state_ff == ST_FINISH && stale_pend_ff);
    abort_c: cover property (busy && abort_s);
    pd_c: cover property (pd_s && start_fall && state_ff == ST_READY);

endmodule : sar_conversion_control

// *** sar_conv_pkg.sv ***
/*
 * Shared constants and carrier types for the successive-approximation
 * conversion controller.
 * Assumes a single 20 MHz system clock and that all users import this package.
 */
package sar_conv_pkg;

    // ==========================================================
    // Resolution and code values
    // ==========================================================
    localparam int RES_BITS = 16;              // Bits resolved per conversion
    localparam int MSB_POS = 15;               // Index of the first decided bit
    localparam logic [15:0] TRIAL_RST = 16'h0000;   // Trial word at reset
    localparam logic [15:0] MSB_TRIAL = 16'h8000;   // First trial word
    localparam logic [15:0] CODE_TOP = 16'hFFFF;    // Top binary code
    localparam logic [15:0] CODE_BOTTOM = 16'h0000; // Bottom binary code
    localparam logic [3:0] BIT_IDX_RST = 4'hF;      // Bit index at reset

    // ==========================================================
    // Timing, in nanoseconds and derived cycles
    // ==========================================================
    localparam int CLK_PERIOD_NS = 50;         // 20 MHz system clock
    localparam int STEP_TIME_NS = 100;         // One approximation step, least
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_TIME_NS = 280;          // Least acquisition time
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_TIME_NS = 1000000;      // Longest accurate gap in fast modes
    localparam int GAP_CYCLES = GAP_TIME_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Carrier types
    // ==========================================================
    typedef struct packed
    {
        logic high_rate;      // High-rate select strap
        logic rate_option;    // Rate option strap
    } rate_mode_t;

    typedef struct packed
    {
        logic [15:0] code;    // Coded result
        logic stale;          // Fast result of the first launch after reset or after a long gap
    } result_t;

    localparam rate_mode_t MODE_RST = '{high_rate: 1'b0, rate_option: 1'b0};
    localparam result_t RESULT_RST = '{code: 16'h0000, stale: 1'b0};

endpackage : sar_conv_pkg

// *** pin_sync.sv ***
/*
 * Two-flip-flop synchroniser for a group of asynchronous pins.
 * Assumes the pins are quasi-static relative to the clock.
 */
`timescale 1ns/10ps
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] synced
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_ff;

    // ==========================================================
    // Two-stage capture
    // ==========================================================
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta_ff <= '0;
            synced <= '0;
        end
        else
        begin
            meta_ff <= pins;
            synced <= meta_ff;
        end
    end

endmodule : pin_sync

// *** front_end_model.sv ***
/*
 * Behavioural analog front end facing the conversion controller.
 * Assumes the held level is a signed code count and stays still during a conversion.
 */
`timescale 1ns/10ps
module front_end_model
(
    input wire logic signed [17:0] level,
    input wire logic [15:0] dac_trial,
    output logic comparator_high,
    output logic over_range,
    output logic under_range
);
    // ==========================================================
    // Comparator and range flags
    // ==========================================================
    // Keep the trial bit while the level is at or above the trial word
    assign comparator_high = (level >= $signed({2'b00, dac_trial}));
    // Beyond either end of the transfer characteristic
    assign over_range = (level > 18'sh0FFFF);
    assign under_range = (level < 18'sh00000);
endmodule : front_end_model

// *** sar_conversion_control_tb.sv ***
/*
 * Self-checking bench for the conversion controller, with the front end model.
 * Assumes pin-to-busy of 3 clocks, 33 busy cycles and a shortened gap limit.
 */
`timescale 1ns/10ps
module sar_conversion_control_tb;
    import sar_conv_pkg::*;
    // ==========================================================
    // Signals and counters
    // ==========================================================
    localparam int GAP_SIM = 200; // Short gap limit keeps the run brief
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic conversion_start_n = 1'b1;
    logic reset_input = 1'b0;
    logic power_down_input = 1'b0;
    logic high_rate_select = 1'b0;
    logic rate_option = 1'b0;
    logic output_coding_select = 1'b1;
    logic signed [17:0] level = 18'sh00000;
    logic comparator_high, over_range, under_range, busy, sample_hold;
    logic [15:0] dac_trial;
    result_t result;
    rate_mode_t active_mode;
    int n_errors = 0;
    int checked = 0;
    int seed = 77; // Fixed so runs repeat
    int exp_stale = -1; // Below zero: stale flag not judged
    int m;
    logic signed [17:0] corners [8] = '{18'sh00000, 18'sh0FFFF, 18'sh08000, 18'sh07FFF,
                                       18'sh3FFFF, 18'sh10000, 18'sh1FFFF, 18'sh20000};

    always #25 clk = ~clk; // 50 ns period

    sar_conversion_control #(.GAP_LIMIT(GAP_SIM)) sar_conversion_control_i
    (
        .clk(clk), .reset_n(reset_n), .conversion_start_n(conversion_start_n),
        .reset_input(reset_input), .power_down_input(power_down_input),
        .high_rate_select(high_rate_select), .rate_option(rate_option),
        .output_coding_select(output_coding_select), .comparator_high(comparator_high),
        .over_range(over_range), .under_range(under_range), .busy(busy),
        .sample_hold(sample_hold), .dac_trial(dac_trial), .result(result), .active_mode(active_mode)
    );

    front_end_model front_end_model_i
    (
        .level(level), .dac_trial(dac_trial), .comparator_high(comparator_high),
        .over_range(over_range), .under_range(under_range)
    );

    // ==========================================================
    // Helpers
    // ==========================================================
    // Inputs always change 2 ns after the rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask : tick

    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check16

    task automatic check1(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check1

    // Counts are bench values, never design outputs
    task automatic check_count(input string what, input int exp, input int got);
        checked++;
        if (got != exp)
        begin
            n_errors++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_count

    // Saturate, then recode; twos complement flips the top bit
    function automatic logic [15:0] exp_code(input logic signed [17:0] lv, input logic bin);
        logic [15:0] c;
        if (lv > 18'sh0FFFF)
            c = 16'hFFFF;
        else if (lv < 18'sh00000)
            c = 16'h0000;
        else
            c = lv[15:0];
        return bin ? c : {~c[15], c[14:0]};
    endfunction : exp_code

    // One conversion; mid 1 power-down, 2 extra start, 3 abort while busy
    task automatic convert(input logic signed [17:0] lv, input logic bin, input logic hr,
                           input logic ro, input int mid);
        int k;
        logic [15:0] prev;
        prev = result.code;
        level = lv;
        output_coding_select = bin;
        high_rate_select = hr;
        rate_option = ro;
        tick(4);
        conversion_start_n = 1'b0;
        k = 0;
        while (busy !== 1'b1 && k < 10)
        begin
            tick(1);
            k++;
        end
        check_count("launch delay", 3, k);
        check1("hold", 1'b1, sample_hold);
        check16("first trial", 16'h8000, dac_trial);
        k = 1;
        while (busy === 1'b1 && k < 100)
        begin
            if (k == 2)
                conversion_start_n = 1'b1;
            if (k == 8 && mid == 1)
                power_down_input = 1'b1;
            if (k == 8 && mid == 2)
                conversion_start_n = 1'b0;
            if (k == 12 && mid == 2)
                conversion_start_n = 1'b1;
            if (k == 10 && mid == 3)
                reset_input = 1'b1;
            tick(1);
            k++;
        end
        if (mid == 3)
        begin
            check1("abort early", 1'b1, k < 16);
            check16("code kept", prev, result.code);
            tick(3);
            reset_input = 1'b0;
        end
        else
        begin
            check_count("busy cycles", 33, k - 1);
            check16("code", exp_code(lv, bin), result.code);
            check1("hold release", 1'b0, sample_hold);
            check16("mode", {14'h0000, hr, ro}, 16'(active_mode));
            if (exp_stale >= 0)
                check1("stale", exp_stale[0], result.stale);
        end
        // Wait out acquisition so power-down alone must refuse the start
        if (mid == 1)
        begin
            tick(8);
            conversion_start_n = 1'b0;
        end
        tick(10);
        check1("no relaunch", 1'b0, busy);
        conversion_start_n = 1'b1;
        power_down_input = 1'b0;
        tick(6);
    endtask : convert

    task automatic end_of_test;
        $display("Counts: %0d checks, %0d errors", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        tick(8);
        reset_n = 1'b1;
        tick(10);
        // A fast first launch after reset or after a long gap is flagged
        exp_stale = 1;
        convert(18'sh01234, 1'b1, 1'b1, 1'b1, 0);
        exp_stale = 0;
        convert(18'sh0ABCD, 1'b1, 1'b1, 1'b0, 0);
        tick(GAP_SIM * 2);
        exp_stale = 1;
        convert(18'sh05A5A, 1'b0, 1'b1, 1'b0, 0);
        exp_stale = 0;
        convert(18'sh0C3C3, 1'b1, 1'b0, 1'b0, 0);
        $display("Test stale flag done");
        // End codes and saturation in both codings
        for (int i = 0; i < 16; i++)
            convert(corners[i % 8], i[3], 1'b0, 1'b0, 0);
        $display("Test corner codes done");
        // Random levels, codings and modes
        repeat (30)
        begin
            m = {$random(seed)} % 3;
            exp_stale = (m == 0) ? 0 : -1;
            convert($signed({2'b00, 16'($random(seed))}), 1'($random(seed)), m != 0, m == 2, 0);
        end
        $display("Test random conversions done");
        // Power-down, extra start and abort while busy
        exp_stale = -1;
        convert(18'sh04321, 1'b1, 1'b0, 1'b0, 1);
        convert(18'sh0FEDC, 1'b0, 1'b1, 1'b1, 2);
        convert(18'sh01111, 1'b1, 1'b0, 1'b0, 3);
        convert(18'sh02222, 1'b0, 1'b0, 1'b0, 0);
        $display("Test mid-conversion events done");
        end_of_test;
    end

    // Run needs about 3500 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("Error watchdog expired");
        end_of_test;
    end
endmodule : sar_conversion_control_tb
